/* File: shared/dogrh_pkg.sv */
// Package for the grouped digital output register and heartbeat counter.
// Assumes a Modbus engine that decodes function codes and presents word accesses.
package dogrh_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned CHAN_N = 4;
	// Holding register space offset of the grouped output word
	localparam logic [15:0] GROUP_STATE_OFS = 16'h0000;
	// Input register space offset of the heartbeat counter
	localparam logic [15:0] HEARTBEAT_OFS = 16'h0001;
	localparam logic [15:0] GROUP_STATE_RST = 16'h0000;
	localparam logic [15:0] HEARTBEAT_RST = 16'h0000;
	localparam logic [15:0] HEARTBEAT_STEP = 16'h0001;
	localparam logic [3:0] CHAN_MASK = 4'hF;

	typedef enum logic [1:0] {DOGRH_SPACE_COIL, DOGRH_SPACE_INPUT, DOGRH_SPACE_HOLDING, DOGRH_SPACE_DISCRETE} dogrh_space_e;

	typedef struct packed {
		logic valid;
		logic write;
		dogrh_space_e space;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dogrh_req_s;

	typedef struct packed {
		logic hit;
		logic error;
		logic [15:0] rdata;
	} dogrh_rsp_s;
endpackage

/* File: verilog/dogrh_regs.sv */
// Grouped output-state holding register and transfer heartbeat input register.
// Assumes a Modbus engine on the same clock issuing one-cycle word requests and
// a one-cycle pulse for each host-to-network data transfer.
`timescale 1ns/10ps
module dogrh_regs
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic coil_mode_en,
	input wire logic [3:0] coil_state,
	input wire dogrh_pkg::dogrh_req_s req,
	output dogrh_pkg::dogrh_rsp_s rsp,
	input wire logic transfer_pulse,
	output logic [3:0] dout_on,
	output logic grouped_active
);
	logic [3:0] group_reg;
	logic [3:0] group_next;
	logic [15:0] beat_reg;
	logic [15:0] beat_next;
	dogrh_pkg::dogrh_rsp_s rsp_reg;
	dogrh_pkg::dogrh_rsp_s rsp_next;
	logic [3:0] dout_reg;
	logic [3:0] dout_next;
	logic group_hit;
	logic beat_hit;

	// One register slot: valid request, right space, right word offset
	function automatic logic dogrh_slot_match(input dogrh_pkg::dogrh_req_s r, input dogrh_pkg::dogrh_space_e s,
		input logic [15:0] ofs);
		return r.valid && r.space == s && r.addr == ofs;
	endfunction

	// Mode is a single select bit, so both modes can never be live at once
	assign grouped_active = ~coil_mode_en;
	// Holding word is not mapped while coils own the outputs
	assign group_hit = grouped_active
		&& dogrh_slot_match(req, dogrh_pkg::DOGRH_SPACE_HOLDING, dogrh_pkg::GROUP_STATE_OFS);
	// Heartbeat is read-only; a write falls through to the error answer
	assign beat_hit = !req.write
		&& dogrh_slot_match(req, dogrh_pkg::DOGRH_SPACE_INPUT, dogrh_pkg::HEARTBEAT_OFS);

	always_comb
	begin
		group_next = group_reg;
		if (group_hit && req.write)
		begin
			// Whole nibble replaced at once; host must merge unchanged bits
			group_next = req.wdata[3:0] & dogrh_pkg::CHAN_MASK;
		end
	end

	always_comb
	begin
		beat_next = beat_reg;
		if (transfer_pulse)
		begin
			// Natural 16-bit overflow gives the wrap to zero
			beat_next = 16'(beat_reg + dogrh_pkg::HEARTBEAT_STEP);
		end
	end

	// Registered so a mode flip cannot glitch the pins
	always_comb
	begin
		dout_next = coil_mode_en ? coil_state : group_reg;
	end

	always_comb
	begin
		rsp_next.hit = group_hit || beat_hit;
		rsp_next.error = req.valid && !(group_hit || beat_hit);
		rsp_next.rdata = 16'h0000;
		if (group_hit)
		begin
			rsp_next.rdata = {12'h000, group_reg};
		end
		else if (beat_hit)
		begin
			// Count before any same-cycle increment
			rsp_next.rdata = beat_reg;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			group_reg <= dogrh_pkg::GROUP_STATE_RST[3:0];
			beat_reg <= dogrh_pkg::HEARTBEAT_RST;
			dout_reg <= dogrh_pkg::GROUP_STATE_RST[3:0];
			rsp_reg <= '0;
		end
		else
		begin
			group_reg <= group_next;
			beat_reg <= beat_next;
			dout_reg <= dout_next;
			rsp_reg <= rsp_next;
		end
	end

	assign dout_on = dout_reg;
	assign rsp = rsp_reg;

	// Steps of the request-side checked behaviours, shared by the properties below
	sequence grp_write_s;
		group_hit && req.write;
	endsequence

	sequence grp_read_s;
		group_hit && !req.write;
	endsequence

	sequence beat_read_s;
		beat_hit;
	endsequence

	sequence holding_in_coil_s;
		req.valid && coil_mode_en && req.space == dogrh_pkg::DOGRH_SPACE_HOLDING;
	endsequence

	// A write only reaches the pins if the mode has not flipped meanwhile
	sequence grp_write_kept_s;
		grp_write_s ##1 !coil_mode_en;
	endsequence

	sequence refused_s;
		req.valid && !group_hit && !beat_hit;
	endsequence

	property write_reach_p;
		@(posedge clock) disable iff (sys_rst)
		grp_write_kept_s |=> dout_on == $past(req.wdata[3:0], 2);
	endproperty

	property chan_map_p;
		@(posedge clock) disable iff (sys_rst)
		grp_write_kept_s |=> dout_on[0] == $past(req.wdata[0], 2);
	endproperty

	property beat_read_p;
		@(posedge clock) disable iff (sys_rst)
		beat_read_s |=> rsp.hit && !rsp.error && rsp.rdata == $past(beat_reg);
	endproperty

	property refuse_p;
		@(posedge clock) disable iff (sys_rst)
		refused_s |=> rsp.error && !rsp.hit && $stable(group_reg);
	endproperty

	group_write_a: assert property (@(posedge clock) disable iff (sys_rst)
		grp_write_s |=> group_reg == $past(req.wdata[3:0]))
		else $error("grouped write did not load all four channels");

	write_reach_a: assert property (write_reach_p)
		else $error("grouped write did not reach all four outputs");

	chan_map_a: assert property (chan_map_p)
		else $error("bit zero does not drive channel zero");

	group_ignored_a: assert property (@(posedge clock) disable iff (sys_rst)
		coil_mode_en |=> $stable(group_reg))
		else $error("grouped register changed in coil mode");

	coil_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
		coil_mode_en |=> dout_on == $past(coil_state))
		else $error("outputs not owned by coil logic in coil mode");

	dout_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
		!coil_mode_en |=> dout_on == $past(group_reg))
		else $error("outputs do not follow grouped register");

	beat_step_a: assert property (@(posedge clock) disable iff (sys_rst)
		transfer_pulse |=> beat_reg == 16'($past(beat_reg) + 16'h0001))
		else $error("heartbeat did not advance by one");

	beat_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		!transfer_pulse |=> $stable(beat_reg))
		else $error("heartbeat moved without a transfer");

	beat_wrap_a: assert property (@(posedge clock) disable iff (sys_rst)
		transfer_pulse && beat_reg == 16'hFFFF |=> beat_reg == 16'h0000)
		else $error("heartbeat did not wrap to zero");

	beat_read_a: assert property (beat_read_p)
		else $error("heartbeat readback wrong");

	beat_write_a: assert property (@(posedge clock) disable iff (sys_rst)
		dogrh_slot_match(req, dogrh_pkg::DOGRH_SPACE_INPUT, dogrh_pkg::HEARTBEAT_OFS) && req.write
		|=> rsp.error && !rsp.hit)
		else $error("heartbeat write was not refused");

	upper_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
		grp_read_s |=> rsp.rdata[15:4] == 12'h000 && rsp.rdata[3:0] == $past(group_reg))
		else $error("grouped readback wrong");

	grp_hit_a: assert property (@(posedge clock) disable iff (sys_rst)
		grp_read_s |=> rsp.hit && !rsp.error)
		else $error("grouped read not answered");

	mode_excl_a: assert property (@(posedge clock) disable iff (sys_rst)
		holding_in_coil_s |=> rsp.error && !rsp.hit)
		else $error("grouped register reachable in coil mode");

	refuse_a: assert property (refuse_p)
		else $error("refused request answered or changed state");

	reset_zero_a: assert property (@(posedge clock)
		$fell(sys_rst) |-> group_reg == 4'h0 && beat_reg == 16'h0000)
		else $error("registers not zero after reset");

	reset_out_a: assert property (@(posedge clock)
		sys_rst && $past(sys_rst) |-> dout_on == 4'h0 && group_reg == 4'h0 && beat_reg == 16'h0000)
		else $error("outputs not cleared during reset");
endmodule

/* File: tb/dogrh_host.sv */
// Modbus client model issuing word requests.
// Assumes answers registered on the taking edge itself.
`timescale 1ns/10ps
module dogrh_host
(
	input wire logic clock,
	output dogrh_pkg::dogrh_req_s req,
	input wire dogrh_pkg::dogrh_rsp_s rsp
);
	initial req = '0;
	// Request held through its taking edge
	task automatic xfer(input logic w, input dogrh_pkg::dogrh_space_e s, input logic [15:0] a, d,
		output dogrh_pkg::dogrh_rsp_s r);
		@(posedge clock);
		req <= '{1'b1, w, s, a, d};
		@(posedge clock);
		req <= '0;
		#1 r = rsp;
	endtask
endmodule

/* File: tb/tb.sv */
// Random and corner tests of the grouped output and heartbeat registers.
// Assumes the client model in dogrh_host.
`timescale 1ns/10ps
module tb;
	localparam dogrh_pkg::dogrh_space_e HR = dogrh_pkg::DOGRH_SPACE_HOLDING;
	localparam dogrh_pkg::dogrh_space_e IR = dogrh_pkg::DOGRH_SPACE_INPUT;
	logic clock, sys_rst, coil_mode_en, transfer_pulse, grouped_active;
	logic [3:0] coil_state, dout_on, cs;
	logic [15:0] w;
	dogrh_pkg::dogrh_req_s req;
	dogrh_pkg::dogrh_rsp_s rsp, r;
	int err_count = 0, cmp_count = 0;
	dogrh_regs DUT (.clock(clock), .sys_rst(sys_rst), .coil_mode_en(coil_mode_en), .coil_state(coil_state),
		.req(req), .rsp(rsp), .transfer_pulse(transfer_pulse), .dout_on(dout_on), .grouped_active(grouped_active));
	dogrh_host u_host (.clock(clock), .req(req), .rsp(rsp));
	function automatic logic [15:0] grp(input logic [15:0] v);
		return {12'h000, v[3:0]};
	endfunction
	task automatic chk(input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic beats(input int n);
		repeat (n) @(posedge clock) transfer_pulse <= 1'b1;
		@(posedge clock) transfer_pulse <= 1'b0;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial
	begin
		#1000000 err_count++;
		finish_test();
	end
	initial
	begin
		void'($urandom(27941));
		sys_rst = 1'b1;
		coil_mode_en = 1'b0;
		coil_state = 4'h0;
		transfer_pulse = 1'b0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		u_host.xfer(1'b0, HR, 16'h0000, 16'h0000, r);
		chk(r.rdata, 16'h0000);
		u_host.xfer(1'b0, IR, 16'h0001, 16'h0000, r);
		chk(r.rdata, 16'h0000);
		for (int i = 0; i < 12; i++)
		begin
			// Whole word rewritten, so untouched channels must be restated
			w = (i == 0) ? 16'hFFFF : 16'($urandom);
			u_host.xfer(1'b1, HR, 16'h0000, w, r);
			u_host.xfer(1'b0, HR, 16'h0000, 16'h0000, r);
			chk(r.rdata, grp(w));
			chk({15'h0000, r.hit}, 16'h0001);
			chk({12'h000, dout_on}, grp(w));
		end
		// One channel changed: read back, merge, write the whole group
		for (int k = 0; k < 4; k++)
		begin
			u_host.xfer(1'b0, HR, 16'h0000, 16'h0000, r);
			chk(r.rdata, grp(w));
			w = grp(w) ^ (16'h0001 << k);
			u_host.xfer(1'b1, HR, 16'h0000, w, r);
			u_host.xfer(1'b0, HR, 16'h0000, 16'h0000, r);
			chk(r.rdata, grp(w));
		end
		// No per-channel path while grouped
		u_host.xfer(1'b1, dogrh_pkg::DOGRH_SPACE_COIL, 16'h0000, 16'h0001, r);
		chk({14'h0000, r.hit, r.error}, 16'h0001);
		chk({12'h000, dout_on}, grp(w));
		@(posedge clock) coil_mode_en <= 1'b1;
		coil_state <= 4'hA;
		u_host.xfer(1'b1, HR, 16'h0000, 16'h0005, r);
		chk({15'h0000, r.error}, 16'h0001);
		chk({11'h000, grouped_active, dout_on}, 16'h000A);
		for (int i = 0; i < 4; i++)
		begin
			cs = 4'($urandom);
			@(posedge clock) coil_state <= cs;
			@(posedge clock);
			#1 chk({12'h000, dout_on}, {12'h000, cs});
		end
		u_host.xfer(1'b0, HR, 16'h0000, 16'h0000, r);
		chk({14'h0000, r.hit, r.error}, 16'h0001);
		u_host.xfer(1'b1, IR, 16'h0001, 16'h0003, r);
		chk({15'h0000, r.error}, 16'h0001);
		@(posedge clock) coil_mode_en <= 1'b0;
		beats(65535);
		u_host.xfer(1'b0, IR, 16'h0001, 16'h0000, r);
		chk(r.rdata, 16'hFFFF);
		chk({11'h000, grouped_active, dout_on}, 16'h0010 | grp(w));
		beats(1);
		u_host.xfer(1'b0, IR, 16'h0001, 16'h0000, r);
		chk(r.rdata, 16'h0000);
		// Mid-run reset clears both registers and the outputs
		u_host.xfer(1'b1, HR, 16'h0000, 16'h000F, r);
		beats(3);
		u_host.xfer(1'b0, IR, 16'h0001, 16'h0000, r);
		chk(r.rdata, 16'h0003);
		@(posedge clock) sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		#1 chk({12'h000, dout_on}, 16'h0000);
		u_host.xfer(1'b0, HR, 16'h0000, 16'h0000, r);
		chk(r.rdata, 16'h0000);
		u_host.xfer(1'b0, IR, 16'h0001, 16'h0000, r);
		chk(r.rdata, 16'h0000);
		finish_test();
	end
endmodule
